// ### rtl/psia_top.sv
// Start-up sequencing, backplane address allocation and address lookup of the controller.
// Behaviour
// - Valid backed program at power-on runs.
// - Backup retention ends after 30 days.
// - Lost backup forces automatic overall reset first.
// - After reset, load card contents if present.
// - Without card, load stored protected blocks.
// - Unbuffered start runs only with handler present.
// - Log unbuffered overall reset as diagnostic event.
// - Battery flag clears after 30 s charged.
// - Digital modules addressed from zero by slot; code gives first slot 4 address 12.
// - Analog modules at even addresses from 256; code gives first slot 4 address 304.
// - Peripheral space 0..2047, images 0..127.
// - Refresh images at every completed program cycle.
// - Eight configured per rail, 32 per row.
// - Digital 4 bytes, others 16 bytes.
// - Digital start is four times slot minus one.
// - Others: sixteen times slot minus one, plus 256.
// - Configured addresses override automatic ones.
// - Arithmetic moves accumulators 3,4 into 2,3.
// - Serial port stays at station 2, 187.5k.
// - No network address after overall reset.
// - Assigned network address persists until replaced, or cleared by overall reset or factory reset.
// - Power-on follows the mode switch.
`timescale 1ns/1ns
`default_nettype none
module psia_top
    import psia_pkg::*;
#(
    parameter logic [31:0] BATT_CLEAR_CYCLES = BATT_CLEAR_CYC64[31:0]
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic power_good,
    input wire logic ram_valid,
    input wire logic [7:0] off_days,
    input wire logic battery_empty,
    input wire logic battery_full,
    input wire logic run_sel,
    input wire logic handler_present,
    input wire logic card_present,
    input wire logic protected_present,
    input wire logic load_done,
    input wire logic hw_cfg_present,
    input wire psia_slot_s slot_info,
    input wire logic cycle_done,
    input wire logic [10:0] lookup_addr,
    input wire logic ip_assign,
    input wire logic ip_from_hw_cfg,
    input wire logic factory_reset,
    input wire logic [31:0] ip_data,
    input wire psia_acc_op_e acc_op,
    input wire logic [31:0] acc_value,
    output logic running,
    output logic overall_reset,
    output logic diag_unbuffered_reset,
    output logic cell_backup_fault_flag,
    output logic load_req,
    output logic load_from_card,
    output logic [5:0] scan_slot,
    output logic scan_done,
    output logic image_refresh,
    output logic lookup_hit,
    output logic [SLOT_W-1:0] lookup_index,
    output logic [10:0] lookup_offset,
    output logic lookup_in_image,
    output logic ip_valid,
    output logic [31:0] ip_addr,
    output logic [7:0] power_fault_handler_block,
    output logic [6:0] serial_station,
    output logic [15:0] serial_rate_100bps,
    output logic [3:0][31:0] accumulators
);
    typedef struct packed {
        psia_boot_e boot;
        logic [SLOT_W-1:0] idx;
        logic [3:0] rail_cnt;
        logic [31:0] chg_cnt;
        logic bat_flag;
        logic unbuffered;
        logic scanned;
        logic load_req;
        logic from_card;
        logic ovr_pulse;
        logic diag_pulse;
        logic refresh;
        logic hit;
        logic [SLOT_W-1:0] hit_idx;
        logic [10:0] hit_off;
        logic in_image;
        logic ip_valid;
        logic [31:0] ip;
        psia_entry_s [SLOTS-1:0] table_e;
    } psia_state_s;

    psia_state_s s_q;
    psia_state_s s_d;
    psia_entry_s new_entry;
    logic backup_lost;
    logic rail_full;
    logic [SLOTS-1:0] hit_vec;
    logic [SLOTS-1:0][10:0] off_vec;
    logic [5:0] cur_slot;

    assign cur_slot = 6'(s_q.idx) + FIRST_SLOT;
    // The count left over from the previous rail must not refuse a new rail's first slot.
    assign rail_full = hw_cfg_present && (s_q.idx[2:0] != 3'h0)
        && (s_q.rail_cnt >= RAIL_LIMIT);

    psia_addr_calc u_calc (
        .slot_num(cur_slot),
        .slot_info(slot_info),
        .use_cfg(hw_cfg_present),
        .entry(new_entry)
    );

    psia_accu u_accu (
        .clk(clk),
        .reset(reset),
        .op(acc_op),
        .value(acc_value),
        .acc(accumulators)
    );

    // Backed contents are distrusted once the retention window or the cell is gone.
    // A flag still standing from an earlier short power cycle forces the same path.
    assign backup_lost = !ram_valid || (off_days > RETAIN_DAYS) || battery_empty
        || s_q.bat_flag;

    genvar g;
    generate
        for (g = 0; g < SLOTS; g++)
        begin : g_lookup
            logic [11:0] top;
            assign off_vec[g] = lookup_addr - s_q.table_e[g].base;
            assign top = 12'(s_q.table_e[g].base) + 12'(psia_span(s_q.table_e[g].kind));
            assign hit_vec[g] = s_q.table_e[g].valid && (lookup_addr >= s_q.table_e[g].base)
                && (12'(lookup_addr) < top);
        end
    endgenerate

    always_comb
    begin
        s_d = s_q;
        s_d.ovr_pulse = 1'b0;
        s_d.diag_pulse = 1'b0;
        s_d.refresh = 1'b0;

        s_d.hit = |hit_vec;
        s_d.hit_idx = '0;
        s_d.hit_off = '0;
        for (int i = SLOTS - 1; i >= 0; i--)
        begin
            if (hit_vec[i])
            begin
                s_d.hit_idx = SLOT_W'(i);
                s_d.hit_off = off_vec[i];
            end
        end
        s_d.in_image = lookup_addr < IMAGE_SIZE;

        // The flag only drops after one long enough interval on a charged cell.
        if (power_good && battery_full && s_q.bat_flag)
        begin
            if (s_q.chg_cnt >= BATT_CLEAR_CYCLES - 32'h0000_0001)
            begin
                s_d.bat_flag = 1'b0;
                s_d.chg_cnt = '0;
            end
            else
            begin
                s_d.chg_cnt = s_q.chg_cnt + 32'h0000_0001;
            end
        end
        else
        begin
            s_d.chg_cnt = '0;
        end

        if (ip_from_hw_cfg || ip_assign)
        begin
            s_d.ip = ip_data;
            s_d.ip_valid = 1'b1;
        end
        if (factory_reset)
        begin
            s_d.ip = '0;
            s_d.ip_valid = 1'b0;
        end

        unique case (s_q.boot)
            BOOT_OFF:
            begin
                if (power_good)
                begin
                    s_d.boot = BOOT_CHECK;
                end
            end
            BOOT_CHECK:
            begin
                s_d.idx = '0;
                s_d.rail_cnt = '0;
                s_d.scanned = 1'b0;
                if (battery_empty)
                begin
                    s_d.bat_flag = 1'b1;
                end
                s_d.unbuffered = backup_lost;
                s_d.boot = backup_lost ? BOOT_RESET : BOOT_SCAN;
            end
            BOOT_RESET:
            begin
                s_d.ovr_pulse = 1'b1;
                s_d.diag_pulse = 1'b1;
                s_d.ip = '0;
                s_d.ip_valid = 1'b0;
                s_d.table_e = '0;
                s_d.from_card = card_present;
                s_d.load_req = card_present || protected_present;
                s_d.boot = BOOT_LOAD;
            end
            BOOT_LOAD:
            begin
                if (!s_q.load_req || load_done)
                begin
                    s_d.load_req = 1'b0;
                    s_d.boot = BOOT_SCAN;
                end
            end
            BOOT_SCAN:
            begin
                if (s_q.idx[2:0] == 3'h0)
                begin
                    s_d.rail_cnt = '0;
                end
                if (new_entry.valid && !rail_full)
                begin
                    s_d.table_e[s_q.idx] = new_entry;
                    if (s_q.idx[2:0] != 3'h0)
                    begin
                        s_d.rail_cnt = s_q.rail_cnt + 4'h1;
                    end
                    else
                    begin
                        s_d.rail_cnt = 4'h1;
                    end
                end
                else
                begin
                    s_d.table_e[s_q.idx] = '0;
                end
                if (s_q.idx == SLOT_W'(SLOTS - 1))
                begin
                    s_d.scanned = 1'b1;
                    s_d.boot = BOOT_STOP;
                end
                else
                begin
                    s_d.idx = s_q.idx + SLOT_W'(1);
                end
            end
            BOOT_STOP:
            begin
                if (run_sel && s_q.scanned && (!s_q.unbuffered || handler_present))
                begin
                    s_d.boot = BOOT_RUN;
                end
            end
            BOOT_RUN:
            begin
                // A cycle that completes as the switch leaves run still gets its refresh.
                if (cycle_done)
                begin
                    s_d.refresh = 1'b1;
                end
                if (!run_sel)
                begin
                    s_d.boot = BOOT_STOP;
                end
            end
            default:
            begin
                s_d.boot = BOOT_OFF;
            end
        endcase

        if (!power_good)
        begin
            s_d.boot = BOOT_OFF;
            s_d.load_req = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            s_q <= '0;
            s_q.boot <= BOOT_OFF;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign running = s_q.boot == BOOT_RUN;
    assign overall_reset = s_q.ovr_pulse;
    assign diag_unbuffered_reset = s_q.diag_pulse;
    assign cell_backup_fault_flag = s_q.bat_flag;
    assign load_req = s_q.load_req;
    assign load_from_card = s_q.from_card;
    assign scan_slot = cur_slot;
    assign scan_done = s_q.scanned;
    assign image_refresh = s_q.refresh;
    assign lookup_hit = s_q.hit;
    assign lookup_index = s_q.hit_idx;
    assign lookup_offset = s_q.hit_off;
    assign lookup_in_image = s_q.in_image;
    assign ip_valid = s_q.ip_valid;
    assign ip_addr = s_q.ip;
    assign power_fault_handler_block = PWR_FAULT_BLOCK;
    assign serial_station = SERIAL_STATION;
    assign serial_rate_100bps = SERIAL_RATE_100BPS;
endmodule
`default_nettype wire

// ### rtl/psia_pkg.sv
// Shared constants, types and helpers for the start-up and I/O addressing block.
package psia_pkg;

    localparam int SLOTS = 32;
    localparam int SLOT_W = 5;
    localparam logic [2:0] RAIL_MASK = 3'h7;
    localparam logic [3:0] RAIL_LIMIT = 4'h8;
    localparam logic [5:0] FIRST_SLOT = 6'h04;
    localparam logic [10:0] DIO_BYTES = 11'h004;
    localparam logic [10:0] SPAN_BYTES = 11'h010;
    localparam logic [10:0] ANA_BASE = 11'h100;
    localparam logic [11:0] IO_SPACE = 12'h800;
    localparam logic [10:0] IMAGE_SIZE = 11'h080;
    localparam logic [7:0] RETAIN_DAYS = 8'h1e;
    localparam int BATT_CLEAR_SEC = 30;
    localparam int CLK_HZ = 100_000_000;
    localparam logic [63:0] BATT_CLEAR_CYC64 = 64'(BATT_CLEAR_SEC) * 64'(CLK_HZ);
    localparam logic [7:0] PWR_FAULT_BLOCK = 8'h51;
    localparam logic [6:0] SERIAL_STATION = 7'h02;
    localparam logic [15:0] SERIAL_RATE_100BPS = 16'h0753;

    typedef enum logic [2:0] {
        KIND_NONE,
        KIND_DIGITAL,
        KIND_ANALOG,
        KIND_FUNC,
        KIND_COMM
    } psia_kind_e;

    typedef enum logic [1:0] {
        ACC_NOP,
        ACC_LOAD,
        ACC_ARITH
    } psia_acc_op_e;

    typedef enum {
        BOOT_OFF,
        BOOT_CHECK,
        BOOT_RESET,
        BOOT_LOAD,
        BOOT_SCAN,
        BOOT_STOP,
        BOOT_RUN
    } psia_boot_e;

    typedef struct packed {
        logic valid;
        psia_kind_e kind;
        logic [10:0] base;
    } psia_entry_s;

    typedef struct packed {
        psia_kind_e kind;
        logic cfg_valid;
        logic [10:0] cfg_addr;
    } psia_slot_s;

    typedef struct packed {
        logic [3:0][31:0] acc;
    } psia_accu_s;

    function automatic logic [10:0] psia_span(input psia_kind_e k);
        if (k == KIND_DIGITAL)
        begin
            return DIO_BYTES;
        end
        return SPAN_BYTES;
    endfunction

endpackage

// ### rtl/psia_addr_calc.sv
// Computes the bus address entry of one backplane slot.
`timescale 1ns/1ns
`default_nettype none
module psia_addr_calc
    import psia_pkg::*;
(
    input wire logic [5:0] slot_num,
    input wire psia_slot_s slot_info,
    input wire logic use_cfg,
    output psia_entry_s entry
);
    logic [10:0] slot_m1;
    logic [10:0] base;
    logic [11:0] top;

    always_comb
    begin
        slot_m1 = 11'(slot_num) - 11'h001;
        if (use_cfg)
        begin
            base = slot_info.cfg_addr;
        end
        else if (slot_info.kind == KIND_DIGITAL)
        begin
            base = 11'(slot_m1 << 2);
        end
        else
        begin
            base = 11'(slot_m1 << 4) + ANA_BASE;
        end
        top = 12'(base) + 12'(psia_span(slot_info.kind));
        entry.kind = slot_info.kind;
        entry.base = base;
        // An entry that would run past the peripheral space is not mapped at all.
        entry.valid = (slot_info.kind != KIND_NONE) && (top <= IO_SPACE)
            && (!use_cfg || slot_info.cfg_valid);
    end
endmodule
`default_nettype wire

// ### rtl/psia_accu.sv
// Four-deep accumulator stack with the arithmetic side effect on the upper accumulators.
`timescale 1ns/1ns
`default_nettype none
module psia_accu
    import psia_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire psia_acc_op_e op,
    input wire logic [31:0] value,
    output logic [3:0][31:0] acc
);
    psia_accu_s s_q;
    psia_accu_s s_d;

    always_comb
    begin
        s_d = s_q;
        unique case (op)
            ACC_NOP:
            begin
                s_d = s_q;
            end
            ACC_LOAD:
            begin
                s_d.acc[3] = s_q.acc[2];
                s_d.acc[2] = s_q.acc[1];
                s_d.acc[1] = s_q.acc[0];
                s_d.acc[0] = value;
            end
            ACC_ARITH:
            begin
                // Programs that expect accumulator 2 untouched will see it overwritten here.
                s_d.acc[0] = value;
                s_d.acc[1] = s_q.acc[2];
                s_d.acc[2] = s_q.acc[3];
            end
            default:
            begin
                s_d = s_q;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign acc = s_q.acc;
endmodule
`default_nettype wire

// ### verif/psia_bus_model.sv
// Backplane module set answering the slot scan with a fixed population.
`timescale 1ns/1ns
`default_nettype none
module psia_bus_model
    import psia_pkg::*;
(
    input wire logic [5:0] scan_slot,
    output var psia_slot_s slot_info
);
    always_comb
    begin
        // Modules sit in plugged order from slot 4, the rest of the row is empty.
        case (scan_slot)
            6'h04: slot_info.kind = KIND_DIGITAL;
            6'h05: slot_info.kind = KIND_ANALOG;
            6'h06: slot_info.kind = KIND_FUNC;
            6'h07: slot_info.kind = KIND_DIGITAL;
            default: slot_info.kind = KIND_NONE;
        endcase
        slot_info.cfg_valid = (slot_info.kind != KIND_NONE);
        slot_info.cfg_addr = {scan_slot, 5'h00};
    end
endmodule
`default_nettype wire

// ### verif/psia_top_chk.sv
// Concurrent checks on the ports of the start-up and addressing block.
`timescale 1ns/1ns
`default_nettype none
module psia_top_chk
    import psia_pkg::*;
#(
    parameter logic [31:0] BATT_CLEAR_CYCLES = 32'h14
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic power_good,
    input wire logic battery_full,
    input wire logic run_sel,
    input wire logic card_present,
    input wire logic cycle_done,
    input wire logic [10:0] lookup_addr,
    input wire psia_acc_op_e acc_op,
    input wire logic running,
    input wire logic overall_reset,
    input wire logic diag_unbuffered_reset,
    input wire logic cell_backup_fault_flag,
    input wire logic load_req,
    input wire logic load_from_card,
    input wire logic scan_done,
    input wire logic image_refresh,
    input wire logic lookup_in_image,
    input wire logic ip_valid,
    input wire logic [7:0] power_fault_handler_block,
    input wire logic [6:0] serial_station,
    input wire logic [15:0] serial_rate_100bps,
    input wire logic [3:0][31:0] accumulators
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic [31:0] ok_q;
    // Counts consecutive charged cycles so an early flag clear is caught.
    always_ff @(posedge clk or posedge reset)
        if (reset)
            ok_q <= '0;
        else
            ok_q <= (power_good && battery_full) ? ok_q + 32'h1 : '0;
    chk_const_pins: assert property (serial_station == SERIAL_STATION
        && serial_rate_100bps == SERIAL_RATE_100BPS && power_fault_handler_block == PWR_FAULT_BLOCK)
        else $error("fixed port value wrong");
    chk_refresh_pulse: assert property (running && cycle_done |=> image_refresh)
        else $error("image refresh missing");
    chk_diag_log: assert property (overall_reset |-> diag_unbuffered_reset)
        else $error("reset not logged");
    chk_reset_first: assert property ($rose(load_req) |-> overall_reset)
        else $error("load before overall reset");
    chk_load_src: assert property (load_req |-> load_from_card == card_present)
        else $error("wrong load source");
    chk_ip_clear: assert property (overall_reset |-> ##[0:1] !ip_valid)
        else $error("address kept after reset");
    chk_acc_shift: assert property (acc_op == ACC_ARITH |=> accumulators[1] ==
        $past(accumulators[2]) && accumulators[2] == $past(accumulators[3]))
        else $error("accumulator shift wrong");
    chk_run_gate: assert property ($rose(running) |-> scan_done && $past(run_sel))
        else $error("run entered too early");
    chk_stop_switch: assert property (running && !run_sel |=> !running)
        else $error("run kept after switch");
    chk_image_bound: assert property (lookup_in_image |-> $past(lookup_addr) < IMAGE_SIZE)
        else $error("image range wrong");
    chk_flag_hold: assert property ($fell(cell_backup_fault_flag)
        |-> ok_q >= BATT_CLEAR_CYCLES - 32'h1)
        else $error("fault flag cleared early");
    cov_run: cover property ($rose(running));
    cov_reset: cover property (overall_reset);
    cov_refresh: cover property (image_refresh);
endmodule
bind psia_top psia_top_chk #(.BATT_CLEAR_CYCLES(BATT_CLEAR_CYCLES)) i_psia_top_chk (
    .clk(clk), .reset(reset), .power_good(power_good), .battery_full(battery_full),
    .run_sel(run_sel), .card_present(card_present), .cycle_done(cycle_done),
    .lookup_addr(lookup_addr), .acc_op(acc_op), .running(running),
    .overall_reset(overall_reset), .diag_unbuffered_reset(diag_unbuffered_reset),
    .cell_backup_fault_flag(cell_backup_fault_flag), .load_req(load_req),
    .load_from_card(load_from_card), .scan_done(scan_done), .image_refresh(image_refresh),
    .lookup_in_image(lookup_in_image), .ip_valid(ip_valid),
    .power_fault_handler_block(power_fault_handler_block), .serial_station(serial_station),
    .serial_rate_100bps(serial_rate_100bps), .accumulators(accumulators));
`default_nettype wire

// ### verif/psia_top_tb_top.sv
// Self-checking testbench of the start-up and addressing block.
`timescale 1ns/1ns
`default_nettype none
module psia_top_tb_top
    import psia_pkg::*;
;
    logic clk = 1'b0, reset = 1'b1, power_good = 1'b0, ram_valid = 1'b0, battery_empty = 1'b0;
    logic battery_full = 1'b0, run_sel = 1'b1, handler_present = 1'b0, card_present = 1'b0;
    logic protected_present = 1'b1, load_done = 1'b0, hw_cfg_present = 1'b0, cycle_done = 1'b0;
    logic ip_assign = 1'b0, factory_reset = 1'b0, ip_from_hw_cfg = 1'b0;
    logic [7:0] off_days = 8'h00;
    logic [10:0] lookup_addr = 11'h000;
    logic [31:0] ip_data = 32'h0, acc_value = 32'h0;
    psia_acc_op_e acc_op = ACC_NOP;
    psia_slot_s slot_info;
    logic running, overall_reset, diag_unbuffered_reset, cell_backup_fault_flag, load_req;
    logic load_from_card, scan_done, image_refresh, lookup_hit, lookup_in_image, ip_valid;
    logic [5:0] scan_slot;
    logic [SLOT_W-1:0] lookup_index;
    logic [10:0] lookup_offset, base;
    logic [31:0] ip_addr;
    logic [7:0] power_fault_handler_block;
    logic [6:0] serial_station;
    logic [15:0] serial_rate_100bps;
    logic [3:0][31:0] accumulators;
    int fail_count = 0, n_tests = 0, n_or = 0, n_diag = 0, n_ref = 0;

    psia_top #(.BATT_CLEAR_CYCLES(32'h14)) i_psia_top (.clk(clk), .reset(reset),
        .power_good(power_good), .ram_valid(ram_valid), .off_days(off_days),
        .battery_empty(battery_empty), .battery_full(battery_full), .run_sel(run_sel),
        .handler_present(handler_present), .card_present(card_present),
        .protected_present(protected_present), .load_done(load_done),
        .hw_cfg_present(hw_cfg_present), .slot_info(slot_info), .cycle_done(cycle_done),
        .lookup_addr(lookup_addr), .ip_assign(ip_assign), .ip_from_hw_cfg(ip_from_hw_cfg),
        .factory_reset(factory_reset), .ip_data(ip_data), .acc_op(acc_op),
        .acc_value(acc_value), .running(running), .overall_reset(overall_reset),
        .diag_unbuffered_reset(diag_unbuffered_reset),
        .cell_backup_fault_flag(cell_backup_fault_flag), .load_req(load_req),
        .load_from_card(load_from_card), .scan_slot(scan_slot), .scan_done(scan_done),
        .image_refresh(image_refresh), .lookup_hit(lookup_hit), .lookup_index(lookup_index),
        .lookup_offset(lookup_offset), .lookup_in_image(lookup_in_image),
        .ip_valid(ip_valid), .ip_addr(ip_addr),
        .power_fault_handler_block(power_fault_handler_block),
        .serial_station(serial_station), .serial_rate_100bps(serial_rate_100bps),
        .accumulators(accumulators));
    psia_bus_model i_psia_bus_model (.scan_slot(scan_slot), .slot_info(slot_info));

    always #5 clk = ~clk;
    // Pulses are counted at the edge so a one-cycle output is never missed.
    always @(posedge clk)
    begin
        n_or += int'(overall_reset);
        n_diag += int'(diag_unbuffered_reset);
        n_ref += int'(image_refresh);
    end

    task complete_run();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            fail_count++;
            $display("mismatch %s expected %0h seen %0h", n, e, g);
        end
    endtask

    function automatic logic pick(input int k);
        return (k == 0) ? running : (k == 1) ? load_req : scan_done;
    endfunction

    task wait_for(input int k);
        int i;
        i = 0;
        while (pick(k) !== 1'b1 && i < 300)
        begin
            @(negedge clk);
            i++;
        end
        chk("wait", 1, pick(k));
        if (pick(k) !== 1'b1)
            complete_run();
    endtask

    task boot(input logic [7:0] days, input logic empty, input logic card);
        power_good = 1'b0;
        repeat (2) @(negedge clk);
        ram_valid = 1'b1;
        off_days = days;
        battery_empty = empty;
        card_present = card;
        n_or = 0;
        n_diag = 0;
        power_good = 1'b1;
    endtask

    task sc_buffered();
        boot(8'h1e, 1'b0, 1'b0);
        wait_for(0);
        chk("overall_reset", 0, n_or);
        chk("station", 32'(SERIAL_STATION), 32'(serial_station));
        chk("rate", 32'(SERIAL_RATE_100BPS), 32'(serial_rate_100bps));
        chk("handler_block", 32'(PWR_FAULT_BLOCK), 32'(power_fault_handler_block));
    endtask

    task sc_lookup();
        for (int i = 0; i < 4; i++)
        begin
            base = (i == 1 || i == 2) ? SPAN_BYTES * 11'(3 + i) + ANA_BASE : DIO_BYTES * 11'(3 + i);
            lookup_addr = base + 11'(i);
            @(negedge clk);
            chk("hit", {1'b1, 5'(i), 11'(i)}, {lookup_hit, lookup_index, lookup_offset});
            chk("in_image", 32'(lookup_addr < IMAGE_SIZE), lookup_in_image);
        end
        // First byte past the digital module in the first slot.
        lookup_addr = DIO_BYTES * 11'h004;
        @(negedge clk);
        chk("miss", 0, lookup_hit);
    endtask

    task sc_refresh();
        n_ref = 0;
        cycle_done = 1'b1;
        @(negedge clk);
        cycle_done = 1'b0;
        repeat (2) @(negedge clk);
        chk("refresh", 1, n_ref);
    endtask

    task sc_ip();
        ip_data = 32'hc0a8_0001;
        ip_assign = 1'b1;
        @(negedge clk);
        ip_assign = 1'b0;
        @(negedge clk);
        chk("ip", {31'h0, 1'b1} ^ ip_data ^ 32'h1, ip_addr);
        factory_reset = 1'b1;
        @(negedge clk);
        factory_reset = 1'b0;
        @(negedge clk);
        chk("ip_valid", 0, ip_valid);
        ip_assign = 1'b1;
        @(negedge clk);
        ip_assign = 1'b0;
        @(negedge clk);
        chk("ip_valid", 1, ip_valid);
        ip_data = 32'h0a00_0002;
        ip_from_hw_cfg = 1'b1;
        @(negedge clk);
        ip_from_hw_cfg = 1'b0;
        @(negedge clk);
        chk("ip_hw", 32'h0a00_0002, ip_addr);
    endtask

    task sc_accu();
        acc_op = ACC_LOAD;
        for (int v = 1; v < 5; v++)
        begin
            acc_value = 32'(v);
            @(negedge clk);
        end
        acc_op = ACC_ARITH;
        acc_value = 32'h9;
        @(negedge clk);
        acc_op = ACC_NOP;
        chk("acc2", 32'h2, accumulators[1]);
        chk("acc3", 32'h1, accumulators[2]);
        chk("acc4", 32'h1, accumulators[3]);
        chk("acc1", 32'h9, accumulators[0]);
    endtask

    task sc_lost(input logic [7:0] days, input logic empty, input logic card, input logic hnd);
        handler_present = hnd;
        hw_cfg_present = 1'b1;
        boot(days, empty, card);
        wait_for(1);
        chk("from_card", card, load_from_card);
        load_done = 1'b1;
        @(negedge clk);
        load_done = 1'b0;
        wait_for(2);
        lookup_addr = 11'h080;
        repeat (3) @(negedge clk);
        chk("overall_reset", 1, n_or);
        chk("diag", 1, n_diag);
        chk("ip_valid", 0, ip_valid);
        chk("running", hnd, running);
        chk("flag", empty, cell_backup_fault_flag);
        chk("scan_slot", 32'(FIRST_SLOT) + 32'(SLOTS - 1), 32'(scan_slot));
        chk("cfg", 2, {lookup_hit, lookup_in_image});
    endtask

    task sc_flag();
        battery_empty = 1'b0;
        battery_full = 1'b1;
        repeat (10) @(negedge clk);
        chk("flag", 1, cell_backup_fault_flag);
        repeat (15) @(negedge clk);
        chk("flag", 0, cell_backup_fault_flag);
        run_sel = 1'b0;
        repeat (2) @(negedge clk);
        chk("running", 0, running);
    endtask

    initial
    begin
        repeat (4) @(negedge clk);
        reset = 1'b0;
        sc_buffered();
        sc_lookup();
        sc_refresh();
        sc_ip();
        sc_accu();
        sc_lost(8'h1f, 1'b0, 1'b1, 1'b0);
        sc_lost(8'h00, 1'b1, 1'b0, 1'b1);
        sc_flag();
        complete_run();
    end
endmodule
`default_nettype wire
